// >>> verilog/synth_latch_defs.vh
`ifndef SYNTH_LATCH_DEFS_VH
`define SYNTH_LATCH_DEFS_VH
// Word and address field
`define WORD_BITS        24
`define ADDR_CONTROL     2'b00
`define ADDR_NCOUNT      2'b10
`define ADDR_RCOUNT      2'b01
// Control word fields
`define CTL_PRESC_LSB    22
`define CTL_PD_SYNC      21
`define CTL_PD_EN        20
`define CTL_CUR_B_LSB    17
`define CTL_CUR_A_LSB    14
`define CTL_OUTPWR_LSB   12
`define CTL_MUTE         11
`define CTL_GAIN         10
`define CTL_TRISTATE     9
`define CTL_POLARITY     8
`define CTL_MUX_LSB      5
`define CTL_CNT_RESET    4
`define CTL_CORE_LSB     2
// Feedback word fields
`define N_DIV2_SEL       23
`define N_DIV2           22
`define N_GAIN           21
`define N_MAIN_LSB       8
`define N_SWALLOW_LSB    2
// Reference word fields
`define R_BAND_LSB       20
`define R_TEST           19
`define R_LOCK_PREC      18
`define R_ABL_LSB        16
`define R_REF_LSB        2
// Lock counts
`define LOCK_CYC_FINE    3'h5
`define LOCK_CYC_COARSE  3'h3
// Prescaler moduli
`define PRESC_0          4'h8
`define PRESC_1          5'h10
`define PRESC_2          6'h20
`endif

// >>> verilog/serial_word_shifter.v
`include "synth_latch_defs.vh"

// Shifts serial data on the rising serial clock edge; emits a word at load rise.
module serial_word_shifter (
  // Clock and reset
  input  wire                    clock,
  input  wire                    rst_n,
  // Synchronised serial pins
  input  wire                    sclk_s,
  input  wire                    sdata_s,
  input  wire                    load_s,
  // Captured word
  output reg  [`WORD_BITS-1:0]   word_r,
  output reg                     word_stb_r
);

  reg [`WORD_BITS-1:0] shift_r;
  reg                  sclk_d_r;
  reg                  load_d_r;

  // Shift MSB first; load rise moves the last 24 bits out
  always @(posedge clock) begin
    if (!rst_n) begin
      shift_r    <= {`WORD_BITS{1'b0}};
      word_r     <= {`WORD_BITS{1'b0}};
      word_stb_r <= 1'b0;
      sclk_d_r   <= 1'b0;
      load_d_r   <= 1'b0;
    end else begin
      sclk_d_r   <= sclk_s;
      load_d_r   <= load_s;
      word_stb_r <= load_s & ~load_d_r;
      if (sclk_s & ~sclk_d_r)
        shift_r <= {shift_r[`WORD_BITS-2:0], sdata_s};
      if (load_s & ~load_d_r)
        word_r <= shift_r;
    end
  end

endmodule

// >>> verilog/synth_latch_power_control.v
`include "synth_latch_defs.vh"

module synth_latch_power_control (
  // Clock and reset
  input  wire         clock,
  input  wire         rst_n,
  // Serial pins
  input  wire         sclk_pin,
  input  wire         sdata_pin,
  input  wire         load_strobe,
  input  wire         chip_enable,
  // Loop status from the analog side
  input  wire         ref_div_tick,
  input  wire         phase_ok,
  // Power state
  output reg          powered_down_r,
  output reg          counters_load_r,
  output reg          ref_buffer_en_r,
  output reg          rf_out_en_r,
  output reg          lock_detect_r,
  // Charge pump
  output reg          pump_tristate_r,
  output reg  [2:0]   pump_current_r,
  output reg          detector_polarity_r,
  output reg          counter_reset_r,
  // Dividers
  output reg  [4:0]   swallow_count_r,
  output reg  [12:0]  main_feedback_count_r,
  output reg  [18:0]  feedback_ratio_r,
  output reg  [13:0]  reference_divide_r,
  output reg          out_div2_r,
  output reg          presc_from_div2_r,
  output reg          band_clk_r,
  // Stored analog settings
  output reg  [1:0]   prescaler_sel_r,
  output reg  [1:0]   out_power_r,
  output reg  [1:0]   core_power_r,
  output reg  [2:0]   mux_sel_r,
  output reg  [1:0]   antibacklash_r
);

  localparam ST_RUN  = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_DOWN = 3'b100;

  // Pin synchronisers, two stages each
  reg  [3:0] sync1_r;
  reg  [3:0] sync2_r;
  wire [`WORD_BITS-1:0] word;
  wire       word_stb;

  always @(posedge clock) begin
    if (!rst_n) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= {chip_enable, load_strobe, sdata_pin, sclk_pin};
      sync2_r <= sync1_r;
    end
  end

  serial_word_shifter u_shift (
    .clock      (clock),
    .rst_n      (rst_n),
    .sclk_s     (sync2_r[0]),
    .sdata_s    (sync2_r[1]),
    .load_s     (sync2_r[2]),
    .word_r     (word),
    .word_stb_r (word_stb)
  );

  wire ce_s = sync2_r[3];

  // Latched control bits
  reg        pd_en_r;
  reg        pd_sync_r;
  reg        gain_r;
  reg        mute_r;
  reg        tristate_bit_r;
  reg  [2:0] cur_a_r;
  reg  [2:0] cur_b_r;
  reg        lock_prec_r;
  reg  [1:0] band_div_r;
  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg  [1:0] wait_edges_r;
  reg  [2:0] good_cnt_r;
  reg  [2:0] band_cnt_r;

  // Prescaler modulus decode, used by the ratio product
  function [5:0] presc_mod;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   presc_mod = {2'b00, `PRESC_0};
        2'b01:   presc_mod = {1'b0, `PRESC_1};
        default: presc_mod = `PRESC_2;
      endcase
    end
  endfunction

  // Band divider ratio decode: 1, 2, 4, 8
  function [2:0] band_mask;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   band_mask = 3'h0;
        2'b01:   band_mask = 3'h1;
        2'b10:   band_mask = 3'h3;
        default: band_mask = 3'h7;
      endcase
    end
  endfunction

  // Address decode shared by the three latch strobes
  function addr_hit;
    input [1:0] addr;
    input [1:0] code;
    begin
      addr_hit = (addr == code);
    end
  endfunction

  wire ctl_wr = word_stb && addr_hit(word[1:0], `ADDR_CONTROL);
  wire n_wr   = word_stb && addr_hit(word[1:0], `ADDR_NCOUNT);
  wire r_wr   = word_stb && addr_hit(word[1:0], `ADDR_RCOUNT);

  always @(posedge clock) begin
    if (!rst_n) begin
      pd_en_r               <= 1'b0;
      pd_sync_r             <= 1'b0;
      gain_r                <= 1'b0;
      mute_r                <= 1'b0;
      tristate_bit_r        <= 1'b0;
      cur_a_r               <= 3'h0;
      cur_b_r               <= 3'h0;
      detector_polarity_r   <= 1'b0;
      counter_reset_r       <= 1'b0;
      prescaler_sel_r       <= 2'h0;
      out_power_r           <= 2'h0;
      core_power_r          <= 2'h0;
      mux_sel_r             <= 3'h0;
      swallow_count_r       <= 5'h00;
      main_feedback_count_r <= 13'h0003;
      out_div2_r            <= 1'b0;
      presc_from_div2_r     <= 1'b0;
      reference_divide_r    <= 14'h0001;
      antibacklash_r        <= 2'h0;
      lock_prec_r           <= 1'b0;
      band_div_r            <= 2'h0;
    end else begin
      if (ctl_wr) begin
        prescaler_sel_r     <= word[`CTL_PRESC_LSB+1:`CTL_PRESC_LSB];
        pd_sync_r           <= word[`CTL_PD_SYNC];
        pd_en_r             <= word[`CTL_PD_EN];
        cur_b_r             <= word[`CTL_CUR_B_LSB+2:`CTL_CUR_B_LSB];
        cur_a_r             <= word[`CTL_CUR_A_LSB+2:`CTL_CUR_A_LSB];
        out_power_r         <= word[`CTL_OUTPWR_LSB+1:`CTL_OUTPWR_LSB];
        mute_r              <= word[`CTL_MUTE];
        gain_r              <= word[`CTL_GAIN];
        tristate_bit_r      <= word[`CTL_TRISTATE];
        detector_polarity_r <= word[`CTL_POLARITY];
        mux_sel_r           <= word[`CTL_MUX_LSB+2:`CTL_MUX_LSB];
        counter_reset_r     <= word[`CTL_CNT_RESET];
        core_power_r        <= word[`CTL_CORE_LSB+1:`CTL_CORE_LSB];
      end
      if (n_wr) begin
        presc_from_div2_r     <= word[`N_DIV2_SEL];
        out_div2_r            <= word[`N_DIV2];
        gain_r                <= word[`N_GAIN];
        main_feedback_count_r <= word[`N_MAIN_LSB+12:`N_MAIN_LSB];
        swallow_count_r       <= word[`N_SWALLOW_LSB+4:`N_SWALLOW_LSB];
      end
      if (r_wr) begin
        band_div_r         <= word[`R_BAND_LSB+1:`R_BAND_LSB];
        // Test bit is not kept; with it clear the block behaves normally
        lock_prec_r        <= word[`R_LOCK_PREC];
        antibacklash_r     <= word[`R_ABL_LSB+1:`R_ABL_LSB];
        reference_divide_r <= word[`R_REF_LSB+13:`R_REF_LSB];
      end
    end
  end

  // Power state machine; chip enable low forces power-down in every state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (pd_en_r && !pd_sync_r)
          state_nxt = ST_DOWN;
        // Look at the incoming word: the latched bits only land one cycle later
        else if (ctl_wr && word[`CTL_PD_EN] && word[`CTL_PD_SYNC])
          state_nxt = ST_WAIT;
      end
      // A rewrite that clears either bit ends the wait early
      ST_WAIT: begin
        if (!pd_en_r)
          state_nxt = ST_RUN;
        else if (!pd_sync_r)
          state_nxt = ST_DOWN;
        else if (ref_div_tick && wait_edges_r == 2'h1)
          state_nxt = ST_DOWN;
      end
      ST_DOWN: begin
        if (!pd_en_r)
          state_nxt = ST_RUN;
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      state_r        <= ST_RUN;
      wait_edges_r   <= 2'h0;
      powered_down_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      // Count reference edges since the load rise
      // Two bits suffice: the second edge ends the wait
      if (state_r != ST_WAIT)
        wait_edges_r <= 2'h0;
      else if (ref_div_tick)
        wait_edges_r <= wait_edges_r + 2'h1;
      powered_down_r <= !ce_s || (state_nxt == ST_DOWN);
    end
  end

  // Same term as powered_down_r, so the effects below land on the same edge
  wire pd_now = !ce_s || (state_nxt == ST_DOWN);

  // Run length that declares lock follows the precision bit
  wire [2:0] lock_need = lock_prec_r ? `LOCK_CYC_FINE : `LOCK_CYC_COARSE;

  // lock detect with precision count; cleared in power-down
  always @(posedge clock) begin
    if (!rst_n) begin
      good_cnt_r    <= 3'h0;
      lock_detect_r <= 1'b0;
    end else if (pd_now) begin
      good_cnt_r    <= 3'h0;
      lock_detect_r <= 1'b0;
    end else if (ref_div_tick) begin
      if (!phase_ok) begin
        good_cnt_r    <= 3'h0;
        lock_detect_r <= 1'b0;
      end else if (good_cnt_r != 3'h7) begin
        good_cnt_r <= good_cnt_r + 3'h1;
        if (good_cnt_r + 3'h1 >= lock_need)
          lock_detect_r <= 1'b1;
      end
    end
  end

  // Toggle point of the band divider; a wider mask halves the band clock again
  wire [2:0] band_top = band_mask(band_div_r);

  // band clock from divided reference ticks
  always @(posedge clock) begin
    if (!rst_n) begin
      band_cnt_r <= 3'h0;
      band_clk_r <= 1'b0;
    end else if (pd_now) begin
      band_cnt_r <= 3'h0;
      band_clk_r <= 1'b0;
    end else if (ref_div_tick) begin
      if (band_cnt_r >= band_top) begin
        band_cnt_r <= 3'h0;
        band_clk_r <= ~band_clk_r;
      end else begin
        band_cnt_r <= band_cnt_r + 3'h1;
      end
    end
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      counters_load_r <= 1'b1;
      ref_buffer_en_r <= 1'b0;
      rf_out_en_r     <= 1'b0;
      pump_tristate_r <= 1'b1;
      pump_current_r  <= 3'h0;
    end else begin
      // counter reset joins the load hold
      counters_load_r <= pd_now || counter_reset_r;
      ref_buffer_en_r <= !pd_now;
      rf_out_en_r     <= !pd_now && (!mute_r || lock_detect_r);
      pump_tristate_r <= pd_now || tristate_bit_r;
      pump_current_r  <= gain_r ? cur_b_r : cur_a_r;
    end
  end

  // Operands widened to 19 bits so the product cannot overflow: 32 x 8191 + 31 fits
  wire [18:0] ratio_nxt = {13'h0, presc_mod(prescaler_sel_r)} * {6'h00, main_feedback_count_r} +
                          {14'h0000, swallow_count_r};

  always @(posedge clock) begin
    if (!rst_n)
      feedback_ratio_r <= 19'h0;
    else
      feedback_ratio_r <= ratio_nxt;
  end

endmodule

// >>> verification/host_serial_model.sv
// Host side of the three-wire link; the serial clock stands still low between words
module host_serial_model (
  // Clock
  input  wire logic clock,
  // Serial pins toward the device
  output logic      sclk_pin,
  output logic      sdata_pin,
  output logic      load_strobe
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels at time zero
  initial begin
    sclk_pin = 1'h0;
    sdata_pin = 1'h0;
    load_strobe = 1'h0;
  end

  // Move one small fixed delay past the rising edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Send 24 bits, then raise load
  task automatic send(input logic [23:0] word);
    for (int i = 23; i >= 0; i--) begin
      sdata_pin = word[i];
      wait_clk(4);
      sclk_pin = 1'h1;
      wait_clk(4);
      sclk_pin = 1'h0;
    end
    // Data is stale now; inverting it exposes a late sample
    sdata_pin = ~word[0];
    load_strobe = 1'h1;
    wait_clk(4);
    load_strobe = 1'h0;
    wait_clk(4);
  endtask
endmodule

// >>> verification/synth_latch_checker.sv
module synth_latch_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // Device inputs
  input wire logic        chip_enable,
  input wire logic        ref_div_tick,
  input wire logic        phase_ok,
  // Device outputs
  input wire logic        powered_down_r,
  input wire logic        counters_load_r,
  input wire logic        ref_buffer_en_r,
  input wire logic        rf_out_en_r,
  input wire logic        lock_detect_r,
  input wire logic        pump_tristate_r,
  input wire logic        band_clk_r,
  input wire logic [4:0]  swallow_count_r,
  input wire logic [12:0] main_feedback_count_r,
  input wire logic [1:0]  prescaler_sel_r,
  input wire logic [18:0] feedback_ratio_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0]  good_n;
  logic [18:0] ratio_x;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Good-tick run length; saturates so it never wraps into a false short run
  always @(posedge clock) begin
    if (!rst_n || powered_down_r || (ref_div_tick && !phase_ok))
      good_n <= 3'h0;
    else if (ref_div_tick && good_n != 3'h7)
      good_n <= good_n + 3'h1;
  end

  // Expected ratio; selections 2 and 3 both mean 32
  assign ratio_x = ({6'h0, main_feedback_count_r} << (prescaler_sel_r == 2'h0 ? 3 :
                   prescaler_sel_r == 2'h1 ? 4 : 5)) + {14'h0, swallow_count_r};

  a_ce_forces_down: assert property (!chip_enable |-> ##[0:3] powered_down_r)
    else $error("chip enable low did not power down");
  a_pd_counters_load: assert property (powered_down_r [*2] |-> counters_load_r)
    else $error("counters not loaded in power-down");
  a_pd_pump_off: assert property (powered_down_r [*2] |-> pump_tristate_r)
    else $error("pump driven in power-down");
  a_pd_outputs_off: assert property (powered_down_r [*2] |-> !ref_buffer_en_r && !rf_out_en_r)
    else $error("buffer or outputs on in power-down");
  a_pd_lock_clear: assert property (powered_down_r [*2] |-> !lock_detect_r)
    else $error("lock held in power-down");
  a_ratio_formula: assert property ($past(rst_n) && $stable(swallow_count_r) &&
    $stable(main_feedback_count_r) && $stable(prescaler_sel_r) |=> feedback_ratio_r == $past(ratio_x))
    else $error("feedback ratio wrong");
  a_lock_needs_run: assert property ($rose(lock_detect_r) |->
    $past(ref_div_tick && phase_ok) && good_n >= 3'h3)
    else $error("lock without enough good ticks");
  a_lock_bad_drop: assert property (ref_div_tick && !phase_ok |=> !lock_detect_r)
    else $error("lock kept after bad tick");
  a_band_on_tick: assert property ($changed(band_clk_r) && !powered_down_r &&
    !$past(powered_down_r) |-> $past(ref_div_tick))
    else $error("band clock moved without tick");

  c_lock: cover property ($rose(lock_detect_r));
  c_down: cover property ($rose(powered_down_r));
  c_band: cover property ($changed(band_clk_r));
endmodule

// >>> verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Power-up settling wait, scaled down from milliseconds to keep the run short
  localparam int SETTLE_CYC = 200;
  logic clock, rst_n, sclk_pin, sdata_pin, load_strobe, chip_enable, ref_div_tick, phase_ok;
  logic powered_down_r, counters_load_r, ref_buffer_en_r, rf_out_en_r, lock_detect_r;
  logic pump_tristate_r, detector_polarity_r, counter_reset_r, out_div2_r, presc_from_div2_r;
  logic        band_clk_r, b;
  logic [2:0]  pump_current_r, mux_sel_r;
  logic [4:0]  swallow_count_r;
  logic [12:0] main_feedback_count_r;
  logic [18:0] feedback_ratio_r;
  logic [13:0] reference_divide_r;
  logic [1:0]  prescaler_sel_r, out_power_r, core_power_r, antibacklash_r;
  int          failures = 0, total_checks = 0, cycles = 0, n;

  synth_latch_power_control dut_u (
    .clock                 (clock),
    .rst_n                 (rst_n),
    .sclk_pin              (sclk_pin),
    .sdata_pin             (sdata_pin),
    .load_strobe           (load_strobe),
    .chip_enable           (chip_enable),
    .ref_div_tick          (ref_div_tick),
    .phase_ok              (phase_ok),
    .powered_down_r        (powered_down_r),
    .counters_load_r       (counters_load_r),
    .ref_buffer_en_r       (ref_buffer_en_r),
    .rf_out_en_r           (rf_out_en_r),
    .lock_detect_r         (lock_detect_r),
    .pump_tristate_r       (pump_tristate_r),
    .pump_current_r        (pump_current_r),
    .detector_polarity_r   (detector_polarity_r),
    .counter_reset_r       (counter_reset_r),
    .swallow_count_r       (swallow_count_r),
    .main_feedback_count_r (main_feedback_count_r),
    .feedback_ratio_r      (feedback_ratio_r),
    .reference_divide_r    (reference_divide_r),
    .out_div2_r            (out_div2_r),
    .presc_from_div2_r     (presc_from_div2_r),
    .band_clk_r            (band_clk_r),
    .prescaler_sel_r       (prescaler_sel_r),
    .out_power_r           (out_power_r),
    .core_power_r          (core_power_r),
    .mux_sel_r             (mux_sel_r),
    .antibacklash_r        (antibacklash_r)
  );
  host_serial_model host_u (.clock(clock), .sclk_pin(sclk_pin), .sdata_pin(sdata_pin),
    .load_strobe(load_strobe));

  // Clock, 8 ns period
  initial begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  // Word builders: address in bits 1:0, reserved and test bits zero
  function automatic logic [23:0] ctl(input logic [1:0] pd, input logic mu, g, t, p, r);
    return {2'h1, pd, 3'h5, 3'h2, 2'h3, mu, g, t, p, 3'h6, r, 2'h2, 2'h0};
  endfunction
  function automatic logic [23:0] nw(input logic s, d, g, input logic [12:0] m, input logic [4:0] a);
    return {s, d, g, m, 1'h0, a, 2'h2};
  endfunction
  function automatic logic [23:0] rw(input logic p, input logic [13:0] r);
    return {2'h0, 2'h1, 1'h0, p, 2'h2, r, 2'h1};
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One reference tick with the given phase verdict
  task automatic tick(input logic ok);
    phase_ok = ok;
    ref_div_tick = 1'h1;
    host_u.wait_clk(1);
    ref_div_tick = 1'h0;
    host_u.wait_clk(3);
  endtask

  task automatic end_of_test();
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  // Main sequence
  initial begin
    rst_n = 1'h0;
    chip_enable = 1'h1;
    ref_div_tick = 1'h0;
    phase_ok = 1'h0;
    host_u.wait_clk(20);
    rst_n = 1'h1;
    // Power-up order: reference, control, settle, feedback
    host_u.send(rw(1'h1, 14'h3fff));
    host_u.send(ctl(2'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0));
    chk("gain2", pump_current_r, 3'h5);
    host_u.wait_clk(SETTLE_CYC);
    host_u.send(nw(1'h1, 1'h0, 1'h0, 13'h1fff, 5'h1f));
    chk("ref", reference_divide_r, 14'h3fff);
    chk("fields", {prescaler_sel_r, out_power_r, core_power_r, mux_sel_r, antibacklash_r}, 11'h3da);
    chk("pol1", detector_polarity_r, 1'h1);
    chk("swallow", swallow_count_r, 5'h1f);
    chk("main", main_feedback_count_r, 13'h1fff);
    chk("ratio", feedback_ratio_r, 19'h2000f);
    chk("div", {out_div2_r, presc_from_div2_r}, 2'h1);
    chk("gain_n", pump_current_r, 3'h2);
    chk("muted", rf_out_en_r, 1'h0);
    n = 0;
    for (int i = 0; i < 8; i++) begin
      b = band_clk_r;
      tick(1'h1);
      if (band_clk_r !== b) n++;
      if (i == 3) chk("lock4", lock_detect_r, 1'h0);
    end
    chk("lock5", lock_detect_r, 1'h1);
    chk("band", n, 32'h4);
    chk("unmute", rf_out_en_r, 1'h1);
    tick(1'h0);
    chk("bad", lock_detect_r, 1'h0);
    host_u.send(rw(1'h0, 14'h0001));
    chk("ref1", reference_divide_r, 14'h0001);
    tick(1'h1);
    tick(1'h1);
    chk("lock2", lock_detect_r, 1'h0);
    tick(1'h1);
    chk("lock3", lock_detect_r, 1'h1);
    host_u.send(nw(1'h0, 1'h1, 1'h1, 13'h0003, 5'h00));
    chk("div2", {out_div2_r, presc_from_div2_r}, 2'h2);
    chk("main3", feedback_ratio_r, 19'h30);
    chk("gain_n2", pump_current_r, 3'h5);
    // Prescaler field flipped to 2: modulus 32
    host_u.send(ctl(2'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1) ^ 24'hc00000);
    chk("ratio32", feedback_ratio_r, 19'h60);
    chk("tri", pump_tristate_r, 1'h1);
    chk("crst", counter_reset_r, 1'h1);
    chk("crst_ld", counters_load_r, 1'h1);
    chk("pol0", detector_polarity_r, 1'h0);
    chk("gain1", pump_current_r, 3'h2);
    host_u.send(ctl(2'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0));
    chk("async", powered_down_r, 1'h1);
    chk("pd_fx", {counters_load_r, pump_tristate_r, ref_buffer_en_r, rf_out_en_r, lock_detect_r}, 5'h18);
    host_u.send(ctl(2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0));
    chk("up", {powered_down_r, pump_tristate_r, counters_load_r}, 3'h0);
    host_u.send(ctl(2'h3, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0));
    chk("sync0", powered_down_r, 1'h0);
    tick(1'h1);
    chk("sync1", powered_down_r, 1'h0);
    tick(1'h1);
    chk("sync2", powered_down_r, 1'h1);
    host_u.send(ctl(2'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0));
    chip_enable = 1'h0;
    host_u.wait_clk(4);
    chk("ce_low", powered_down_r, 1'h1);
    // Reference word still latched while powered down
    host_u.send(rw(1'h1, 14'h0155));
    chk("pd_write", reference_divide_r, 14'h0155);
    chip_enable = 1'h1;
    host_u.wait_clk(4);
    chk("ce_high", powered_down_r, 1'h0);
    end_of_test();
  end
endmodule

bind synth_latch_power_control synth_latch_checker chk_u (
  .clock                 (clock),
  .rst_n                 (rst_n),
  .chip_enable           (chip_enable),
  .ref_div_tick          (ref_div_tick),
  .phase_ok              (phase_ok),
  .powered_down_r        (powered_down_r),
  .counters_load_r       (counters_load_r),
  .ref_buffer_en_r       (ref_buffer_en_r),
  .rf_out_en_r           (rf_out_en_r),
  .lock_detect_r         (lock_detect_r),
  .pump_tristate_r       (pump_tristate_r),
  .band_clk_r            (band_clk_r),
  .swallow_count_r       (swallow_count_r),
  .main_feedback_count_r (main_feedback_count_r),
  .prescaler_sel_r       (prescaler_sel_r),
  .feedback_ratio_r      (feedback_ratio_r)
);
